// ==== verilog/pch_config_header.sv ====
// Configuration header registers of function 0 window and function 1 bridge.
// Assumes configuration cycles, memory decode and events arrive on clk from
// the PCI target logic, so no input needs a synchroniser.
// The clock enable freezes all state; reset is synchronous to clk.
`timescale 1ns/1ps
`include "pch_consts.svh"

module pch_config_header #(
  parameter logic [15:0] MAKER_CODE = 16'h5a5a,  // Arbitrary value.
  parameter logic [15:0] PART_CODE  = 16'ha5a5   // Arbitrary value.
) (
  // Clock, reset, enable
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  // Configuration cycles
  input  wire logic                      cfg_rd,
  input  wire logic                      cfg_wr,
  input  wire logic [`PCH_ADDR_W-1:0]    cfg_addr,
  input  wire pch_pkg::pch_be_t          cfg_be,
  input  wire pch_pkg::pch_word_t        cfg_wdata,
  output logic                           cfg_rvalid,
  output pch_pkg::pch_word_t             cfg_rdata,
  // Memory decode
  input  wire logic                      mem_req,
  input  wire logic [31:0]               mem_addr,
  input  wire logic                      fn0_mem_enable,
  output logic                           cfg_window_claim,
  input  wire logic                      local_req,
  input  wire logic                      local_owns_bus,
  output logic                           local_accept,
  output logic                           local_target_abort,
  output logic                           io_claim,
  // Error events and pins
  input  wire logic                      parity_err,
  input  wire logic                      serr_req,
  output logic                           parity_act,
  output logic                           system_error_output_o,
  output logic                           system_error_output_oe_n
);

  // All state advances only while ce is high. A frozen cycle therefore
  // stretches a one-cycle answer instead of losing it, which the target
  // logic must allow for when it stalls the block.

  // Function 0 fields written by the host.
  logic [`PCH_BASE_W-1:0] base_r, base_nxt;
  logic [7:0]             int_line_r, int_line_nxt;

  // Function 1 command bits that can be written.
  logic                   mem_en_r, mem_en_nxt;
  logic                   par_resp_r, par_resp_nxt;
  logic                   serr_en_r, serr_en_nxt;

  // Sticky status flags, one per status event bit that this function can raise.
  localparam int          N_FLAGS = 3;
  localparam int          FL_PAR  = 0;
  localparam int          FL_SERR = 1;
  localparam int          FL_ABT  = 2;
  logic [N_FLAGS-1:0]     flag_r, flag_nxt;
  logic [N_FLAGS-1:0]     flag_set, flag_clr;

  // Registered read answer.
  logic                   rvalid_r, rvalid_nxt;
  pch_pkg::pch_word_t     rdata_r, rdata_nxt;

  // Registered decode answers and pin control.
  logic                   claim_r, claim_nxt;
  logic                   accept_r, accept_nxt;
  logic                   abort_r, abort_nxt;
  logic                   pact_r, pact_nxt;
  logic                   serr_r, serr_nxt;

  // Read-back words and decode terms.
  pch_pkg::pch_word_t     base_word;
  pch_pkg::pch_word_t     intr_word;
  pch_pkg::pch_word_t     ident_word;
  pch_pkg::pch_word_t     cmdstat_word;
  logic                   sel_base, sel_intr, sel_ident, sel_cmd;
  logic                   fn1_on;
  logic                   wr_base, wr_intr, wr_cmd;
  logic                   clr_status;
  logic                   abort_now, serr_now;

  // Read-back words. Fixed fields are spelled out bit by bit so that a
  // wrong constant stands out against the register map.
  always_comb begin
    base_word = 32'h00000000;
    base_word[`PCH_BAR_SPACE_BIT] = 1'b0;
    base_word[`PCH_BAR_TYPE_LSB+1:`PCH_BAR_TYPE_LSB] = 2'b00;
    base_word[`PCH_BAR_PREF_BIT] = 1'b0;
    base_word[`PCH_BAR_ZERO_LSB+:`PCH_BAR_ZERO_W] = 8'h00;
    base_word[`PCH_BASE_LSB+:`PCH_BASE_W] = base_r;
    // The interrupt pin, grant and latency bytes are fixed.
    intr_word = {`PCH_MAX_LATENCY, `PCH_MIN_GRANT, `PCH_INT_PIN, int_line_r};
    // Both identification codes are parameters with arbitrary defaults.
    ident_word = {PART_CODE, MAKER_CODE};
    cmdstat_word = 32'h00000000;
    // Command half.
    cmdstat_word[`PCH_CMD_IO_EN] = 1'b0;
    cmdstat_word[`PCH_CMD_MEM_EN] = mem_en_r;
    cmdstat_word[`PCH_CMD_MASTER_EN] = 1'b0;
    cmdstat_word[`PCH_CMD_SPECIAL] = 1'b0;
    cmdstat_word[`PCH_CMD_WR_INVAL] = 1'b0;
    cmdstat_word[`PCH_CMD_DISPLAY] = 1'b0;
    cmdstat_word[`PCH_CMD_PAR_RESP] = par_resp_r;
    cmdstat_word[`PCH_CMD_STEPPING] = 1'b0;
    cmdstat_word[`PCH_CMD_SERR_EN] = serr_en_r;
    cmdstat_word[`PCH_CMD_B2B_MASTER] = 1'b0;
    cmdstat_word[`PCH_CMD_RSVD_LSB+:`PCH_CMD_RSVD_W] = 6'h00;
    // Status half. Bits that report bus-master events can never be set,
    // since this function never masters the bus.
    cmdstat_word[`PCH_ST_RSVD_LSB+:`PCH_ST_RSVD_W] = 5'h00;
    cmdstat_word[`PCH_ST_66MHZ] = 1'b0;
    cmdstat_word[`PCH_ST_USER_FEAT] = 1'b0;
    cmdstat_word[`PCH_ST_FAST_TGT] = 1'b1;
    cmdstat_word[`PCH_ST_MST_PAR] = 1'b0;
    cmdstat_word[`PCH_ST_DEVSEL_LSB+1:`PCH_ST_DEVSEL_LSB] = `PCH_ST_DEVSEL;
    cmdstat_word[`PCH_ST_ABORT_SIG] = flag_r[FL_ABT];
    cmdstat_word[`PCH_ST_ABORT_RCVD] = 1'b0;
    cmdstat_word[`PCH_ST_MST_ABORT] = 1'b0;
    cmdstat_word[`PCH_ST_SERR_SIG] = flag_r[FL_SERR];
    cmdstat_word[`PCH_ST_PAR_DET] = flag_r[FL_PAR];
  end

  // Register selects are shared by reads and writes.
  assign sel_base   = (cfg_addr == `PCH_OFF_CFG_BASE);
  assign sel_intr   = (cfg_addr == `PCH_OFF_INTR_FN0);
  assign sel_ident  = (cfg_addr == `PCH_OFF_IDENT_FN1);
  assign sel_cmd    = (cfg_addr == `PCH_OFF_CMDSTAT_FN1);

  // Function 1 is logically off the bus while its command half is zero.
  assign fn1_on     = |cmdstat_word[`PCH_CMD_W-1:0];
  assign wr_base    = cfg_wr && sel_base;
  assign wr_intr    = cfg_wr && sel_intr;
  assign wr_cmd     = cfg_wr && sel_cmd;
  assign clr_status = wr_cmd && cfg_be[3];
  // A request that finds the local bus held elsewhere ends in an abort while mem_en_r is set.
  assign abort_now  = local_req && mem_en_r && fn1_on && !local_owns_bus;
  assign serr_now   = serr_req && serr_en_r;

  // Function 0 fields; the interrupt line byte only stores for read-back, no logic uses it.
  // Byte lane 0 of the base register holds only fixed bits, so its enable is
  // ignored.
  always_comb begin
    base_nxt     = base_r;
    int_line_nxt = int_line_r;
    if (wr_base) begin
      if (cfg_be[1]) base_nxt[3:0]   = cfg_wdata[15:12];
      if (cfg_be[2]) base_nxt[11:4]  = cfg_wdata[23:16];
      if (cfg_be[3]) base_nxt[19:12] = cfg_wdata[31:24];
    end
    if (wr_intr && cfg_be[0]) int_line_nxt = cfg_wdata[7:0];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      base_r     <= `PCH_BASE_RST;
      int_line_r <= `PCH_INT_LINE_RST;
    end else if (ce) begin
      base_r     <= base_nxt;
      int_line_r <= int_line_nxt;
    end
  end

  // Function 1 command bits; all three clear on the hardware reset pin.
  always_comb begin
    mem_en_nxt   = mem_en_r;
    par_resp_nxt = par_resp_r;
    serr_en_nxt  = serr_en_r;
    if (wr_cmd && cfg_be[0]) begin
      mem_en_nxt   = cfg_wdata[`PCH_CMD_MEM_EN];
      par_resp_nxt = cfg_wdata[`PCH_CMD_PAR_RESP];
    end
    if (wr_cmd && cfg_be[1]) serr_en_nxt = cfg_wdata[`PCH_CMD_SERR_EN];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_en_r   <= 1'b0;
      par_resp_r <= 1'b0;
      serr_en_r  <= 1'b0;
    end else if (ce) begin
      mem_en_r   <= mem_en_nxt;
      par_resp_r <= par_resp_nxt;
      serr_en_r  <= serr_en_nxt;
    end
  end

  // Event inputs and write-one-to-clear requests, one pair per flag.
  assign flag_set[FL_PAR]  = parity_err;
  assign flag_set[FL_SERR] = serr_req;
  assign flag_set[FL_ABT]  = abort_now;
  assign flag_clr[FL_PAR]  = clr_status && cfg_wdata[`PCH_ST_PAR_DET];
  assign flag_clr[FL_SERR] = clr_status && cfg_wdata[`PCH_ST_SERR_SIG];
  assign flag_clr[FL_ABT]  = clr_status && cfg_wdata[`PCH_ST_ABORT_SIG];

  // An event in the same cycle as a clear wins, so no event is lost to a
  // racing write of one; the host then simply sees the bit still set.
  for (genvar i = 0; i < N_FLAGS; i++) begin : g_flag
    always_comb begin
      flag_nxt[i] = flag_r[i];
      if (flag_clr[i]) flag_nxt[i] = 1'b0;
      if (flag_set[i]) flag_nxt[i] = 1'b1;
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        flag_r[i] <= 1'b0;
      end else if (ce) begin
        flag_r[i] <= flag_nxt[i];
      end
    end
  end

  // Read answer: unmapped offsets give zero so the host never stalls.
  // A read and a write in the same cycle return the old value.
  always_comb begin
    rvalid_nxt = cfg_rd;
    rdata_nxt  = 32'h00000000;
    if (cfg_rd && sel_base) rdata_nxt = base_word;
    if (cfg_rd && sel_intr) rdata_nxt = intr_word;
    if (cfg_rd && sel_ident) rdata_nxt = ident_word;
    if (cfg_rd && sel_cmd) rdata_nxt = cmdstat_word;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
    end else if (ce) begin
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  // Decode answers. The window claim has its own enable input, so the two
  // functions never gate each other.
  always_comb begin
    claim_nxt  = mem_req && fn0_mem_enable &&
                 (mem_addr[31:`PCH_BASE_LSB] == base_r);
    // Accept and abort split on bus ownership, so they never coincide.
    accept_nxt = local_req && mem_en_r && fn1_on && local_owns_bus;
    abort_nxt  = abort_now;
    // Parity action is gated by its enable; the detected flag is not.
    pact_nxt   = parity_err && par_resp_r;
    // The pin follows a request only while its enable is set.
    serr_nxt   = serr_now;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      claim_r  <= 1'b0;
      accept_r <= 1'b0;
      abort_r  <= 1'b0;
      pact_r   <= 1'b0;
      serr_r   <= 1'b0;
    end else if (ce) begin
      claim_r  <= claim_nxt;
      accept_r <= accept_nxt;
      abort_r  <= abort_nxt;
      pact_r   <= pact_nxt;
      serr_r   <= serr_nxt;
    end
  end

  assign cfg_rvalid         = rvalid_r;
  assign cfg_rdata          = rdata_r;
  assign cfg_window_claim   = claim_r;
  assign local_accept       = accept_r;
  assign local_target_abort = abort_r;
  // I/O cycles are never claimed, whatever the host writes to the command half.
  assign io_claim           = 1'b0;
  assign parity_act         = pact_r;
  // Open-drain pin: the level is always low and only the enable moves. The
  // enable is active low, so the pin floats to its pull-up when idle.
  assign system_error_output_o    = 1'b0;
  assign system_error_output_oe_n = !serr_r;

endmodule

// ==== verilog/pch_consts.svh ====
// Offsets, field positions and fixed values of the configuration header registers.
// Assumes byte addresses within one device's configuration space.
`ifndef PCH_CONSTS_SVH
`define PCH_CONSTS_SVH

`define PCH_ADDR_W          9
`define PCH_OFF_CFG_BASE    9'h010
`define PCH_OFF_INTR_FN0    9'h03c
`define PCH_OFF_IDENT_FN1   9'h100
`define PCH_OFF_CMDSTAT_FN1 9'h104

`define PCH_BASE_LSB        12
`define PCH_BASE_W          20
`define PCH_BASE_RST        20'h00000
`define PCH_BASE_LOW_FIXED  12'h000

`define PCH_INT_LINE_RST    8'h00
`define PCH_INT_PIN         8'h01
`define PCH_MIN_GRANT       8'h05
`define PCH_MAX_LATENCY     8'h0f

`define PCH_BAR_SPACE_BIT   0
`define PCH_BAR_TYPE_LSB    1
`define PCH_BAR_PREF_BIT    3
`define PCH_BAR_ZERO_LSB    4
`define PCH_BAR_ZERO_W      8

`define PCH_CMD_W           16
`define PCH_CMD_IO_EN       0
`define PCH_CMD_MEM_EN      1
`define PCH_CMD_MASTER_EN   2
`define PCH_CMD_SPECIAL     3
`define PCH_CMD_WR_INVAL    4
`define PCH_CMD_DISPLAY     5
`define PCH_CMD_PAR_RESP    6
`define PCH_CMD_STEPPING    7
`define PCH_CMD_SERR_EN     8
`define PCH_CMD_B2B_MASTER  9
`define PCH_CMD_RSVD_LSB    10
`define PCH_CMD_RSVD_W      6
`define PCH_ST_RSVD_LSB     16
`define PCH_ST_RSVD_W       5
`define PCH_ST_66MHZ        21
`define PCH_ST_USER_FEAT    22
`define PCH_ST_FAST_TGT     23
`define PCH_ST_MST_PAR      24
`define PCH_ST_DEVSEL_LSB   25
`define PCH_ST_DEVSEL       2'b01
`define PCH_ST_ABORT_SIG    27
`define PCH_ST_ABORT_RCVD   28
`define PCH_ST_MST_ABORT    29
`define PCH_ST_SERR_SIG     30
`define PCH_ST_PAR_DET      31

`endif

// ==== verilog/pch_pkg.sv ====
// Types shared by the configuration header logic.
// Assumes the constants header is included by the design file.
package pch_pkg;
  typedef logic [31:0] pch_word_t;
  typedef logic [3:0]  pch_be_t;
endpackage

// ==== bench/pch_config_header_sva.sv ====
// Port assertions for the configuration header registers.
// Assumes ce is high whenever a request is made, so answers land one cycle later.
`timescale 1ns/1ps
module pch_sva #(
  parameter logic [15:0] MAKER_CODE = 16'h5a5a,
  parameter logic [15:0] PART_CODE  = 16'ha5a5
) (
  // Clock and reset
  input wire logic               clk,
  input wire logic               rst,
  // Configuration cycles
  input wire logic               cfg_rd,
  input wire logic [8:0]         cfg_addr,
  input wire pch_pkg::pch_word_t cfg_rdata,
  // Decode and events
  input wire logic               mem_req,
  input wire logic               cfg_window_claim,
  input wire logic               local_req,
  input wire logic               local_owns_bus,
  input wire logic               local_accept,
  input wire logic               local_target_abort,
  input wire logic               io_claim,
  input wire logic               parity_err,
  input wire logic               parity_act,
  input wire logic               serr_req,
  input wire logic               system_error_output_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_base_low_zero: assert property (cfg_rd && cfg_addr == 9'h010 |=>
    cfg_rdata[11:0] == 12'h000) else $error("base low bits not zero");
  a_timing_fields: assert property (cfg_rd && cfg_addr == 9'h03c |=>
    cfg_rdata[31:8] == 24'h0f0501) else $error("fixed timing fields wrong");
  a_ident_fixed: assert property (cfg_rd && cfg_addr == 9'h100 |=>
    cfg_rdata == {PART_CODE, MAKER_CODE}) else $error("identification wrong");
  a_cmd_fixed_bits: assert property (cfg_rd && cfg_addr == 9'h104 |=>
    (cfg_rdata & 32'h37fffebd) == 32'h02800000) else $error("fixed command bits wrong");
  a_io_never: assert property (!io_claim) else $error("io cycle claimed");
  a_claim_cause: assert property (cfg_window_claim |-> $past(mem_req))
    else $error("claim without request");
  a_accept_owner: assert property (local_accept |-> $past(local_req && local_owns_bus))
    else $error("accept without owned bus");
  a_abort_cause: assert property (local_target_abort |->
    $past(local_req && !local_owns_bus)) else $error("abort without cause");
  a_parity_cause: assert property (parity_act |-> $past(parity_err))
    else $error("parity action without error");
  a_serr_cause: assert property ($fell(system_error_output_oe_n) |-> $past(serr_req))
    else $error("error pin driven without request");
  c_accept: cover property (local_accept);
  c_abort: cover property (local_target_abort);
  c_parity: cover property (parity_act);
  c_serr: cover property (!system_error_output_oe_n);
endmodule
bind pch_config_header pch_sva #(.MAKER_CODE(MAKER_CODE), .PART_CODE(PART_CODE)) u_sva (.*);

// ==== bench/pch_host.sv ====
// Host model issuing configuration cycles to the header registers.
// Assumes tasks are entered just after a falling clock edge.
`timescale 1ns/1ps
module pch_host (
  // Clock
  input wire logic                clk,
  // Configuration cycles
  output logic                    cfg_rd,
  output logic                    cfg_wr,
  output logic [8:0]              cfg_addr,
  output pch_pkg::pch_be_t        cfg_be,
  output pch_pkg::pch_word_t      cfg_wdata,
  input  wire logic               cfg_rvalid,
  input  wire pch_pkg::pch_word_t cfg_rdata
);
  initial begin
    cfg_rd = 1'h0;
    cfg_wr = 1'h0;
    cfg_addr = 9'h000;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
  end
  // Released data is inverted so a stale value can never pass for a fresh one.
  task automatic wr(input logic [8:0] a, input pch_pkg::pch_be_t b, input pch_pkg::pch_word_t d);
    cfg_addr = a;
    cfg_be = b;
    cfg_wdata = d;
    cfg_wr = 1'h1;
    @(negedge clk);
    cfg_wr = 1'h0;
    cfg_wdata = ~d;
    @(negedge clk);
  endtask
  task automatic rd(input logic [8:0] a, output pch_pkg::pch_word_t d, output logic v);
    cfg_addr = a;
    cfg_rd = 1'h1;
    @(negedge clk);
    cfg_rd = 1'h0;
    // The answer stands for one cycle only, so it is taken here.
    d = cfg_rdata;
    v = cfg_rvalid;
    @(negedge clk);
  endtask
endmodule

// ==== bench/pch_config_header_bench.sv ====
// Self-checking bench for the configuration header registers.
// Assumes the host model shares the clock and all pins change on falling edges.
`timescale 1ns/1ps
module pch_config_header_bench;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic mem_req = 1'h0, fn0_en = 1'h0, local_req = 1'h0, owns = 1'h0, perr = 1'h0, serr = 1'h0;
  logic [31:0] mem_addr = 32'h0;
  logic cfg_rd, cfg_wr, claim, acc, abt, act, oe_n, rvalid, io_space_enable, so;
  logic ce_r = 1'h1;
  logic [8:0] cfg_addr;
  pch_pkg::pch_be_t cfg_be;
  pch_pkg::pch_word_t cfg_wdata, cfg_rdata;
  int fails = 0, n_tests = 0, cyc = 0;
  always #12.5 clk = ~clk;
  pch_host host (.clk(clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rvalid(rvalid), .cfg_rdata(cfg_rdata));
  // Identification codes below are arbitrary.
  pch_config_header #(.MAKER_CODE(16'h1234), .PART_CODE(16'h4321)) uut (.clk(clk), .rst(rst),
    .ce(ce_r), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rvalid(rvalid), .cfg_rdata(cfg_rdata), .mem_req(mem_req),
    .mem_addr(mem_addr), .fn0_mem_enable(fn0_en), .cfg_window_claim(claim),
    .local_req(local_req), .local_owns_bus(owns), .local_accept(acc),
    .local_target_abort(abt), .io_claim(io_space_enable), .parity_err(perr), .serr_req(serr),
    .parity_act(act), .system_error_output_o(so), .system_error_output_oe_n(oe_n));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [8:0] a, input logic [31:0] exp);
    pch_pkg::pch_word_t d;
    logic v;
    host.rd(a, d, v);
    chk({31'h0, v}, 32'h1);
    chk(d, exp);
  endtask
  task automatic ev(ref logic s);
    s = 1'h1;
    @(negedge clk);
    s = 1'h0;
  endtask
  task automatic t_regs;
    rchk(9'h104, 32'h02800000);
    host.wr(9'h100, 4'hf, 32'hffffffff);
    rchk(9'h100, 32'h43211234);
    rchk(9'h0f0, 32'h0);
    host.wr(9'h03c, 4'hf, 32'h0000005a);
    rchk(9'h03c, 32'h0f05015a);
    host.wr(9'h010, 4'hf, 32'hffffffff);
    rchk(9'h010, 32'hfffff000);
    mem_addr = 32'hfffff123;
    fn0_en = 1'h1;
    ev(mem_req);
    chk(claim, 32'h1);
    mem_addr = 32'hffffe123;
    ev(mem_req);
    chk(claim, 32'h0);
    chk({30'h0, io_space_enable, so}, 32'h0);
    $display("registers done");
  endtask
  task automatic t_cmd;
    host.wr(9'h104, 4'h3, 32'h0000ffff);
    rchk(9'h104, 32'h02800142);
    owns = 1'h1;
    ev(local_req);
    chk(acc, 32'h1);
    owns = 1'h0;
    ev(local_req);
    chk(abt, 32'h1);
    rchk(9'h104, 32'h0a800142);
    host.wr(9'h104, 4'h8, 32'h08000000);
    rchk(9'h104, 32'h02800142);
    host.wr(9'h104, 4'h3, 32'h0);
    ev(local_req);
    chk({30'h0, acc, abt}, 32'h0);
    $display("command done");
  endtask
  task automatic t_err;
    ev(perr);
    chk(act, 32'h0);
    ev(serr);
    chk(oe_n, 32'h1);
    rchk(9'h104, 32'hc2800000);
    host.wr(9'h104, 4'h3, 32'h00000140);
    ev(perr);
    chk(act, 32'h1);
    ev(serr);
    chk(oe_n, 32'h0);
    host.wr(9'h104, 4'h8, 32'h40000000);
    rchk(9'h104, 32'h82800140);
    rst = 1'h1;
    repeat (2) @(negedge clk);
    rst = 1'h0;
    rchk(9'h104, 32'h02800000);
    ce_r = 1'h0;
    host.wr(9'h03c, 4'h1, 32'h000000a5);
    ce_r = 1'h1;
    rchk(9'h03c, 32'h0f050100);
    $display("errors and reset done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // The whole run needs well under 200 cycles, so 2000 only trips on a hang.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fails++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'h0;
    t_regs;
    t_cmd;
    t_err;
    tally_and_finish;
  end
endmodule
